// ### clh_host_if.sv
// Host port of a character display controller: parallel, SPI and I2C front ends,
// a two-entry command buffer, address counter, glyph and display RAM.
// Assumes all pins are synchronous to clk; straps are stable from reset on.
`timescale 1ns/1ns
`include "clh_regs.svh"

// What this block does
// - Instruction 01xxxxxx loads six address bits, selects glyph RAM.
// - Instruction 1xxxxxxx loads seven address bits, selects display RAM.
// - One-line mode: display addresses run 00H to 4FH contiguously.
// - Two-line mode: line one 00H-27H, line two 40H-67H.
// - Instruction read returns busy on bit 7, address counter below; parallel only.
// - Data write stores the byte in the RAM last selected.
// - Each data write steps the address counter by entry direction.
// - Data read without prior address set returns invalid data first.
// - Display address set or cursor shift prefetches RAM into output register.
// - Each data read steps the address counter by entry direction.
// - After a write, a read still returns the earlier prefetched byte.
// - Parallel and SPI transfers are latched as instruction or data by register select.
// - 4-bit mode uses upper data lines, high nibble first.
// - 4-bit mode raises busy only after the second nibble.
// - 8-bit mode moves a byte in one cycle on all lines.
// - Interface straps pick parallel, I2C or 4-line SPI.
// - SPI uses chip select, serial data, serial clock and register select.
// - SPI clock idles high; bits taken on rising edge.
// - I2C start is data fall, stop is data rise, with clock high.
// - I2C slave answers one of four addresses set by two straps.
// - I2C control byte flags more control bytes and RAM or instruction.
module clh_host_if
  import clh_pkg::*;
#(
  parameter int DD_DEPTH  = 128,
  parameter int CG_DEPTH  = 64,
  parameter int BUSY_CYC  = (`CLH_BUSY_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       iface_strap_high,
  input  wire logic       iface_strap_low,
  input  wire logic       addr_strap_high,
  input  wire logic       addr_strap_low,
  input  wire logic       e_strobe,
  input  wire logic       reg_select,
  input  wire logic       read_not_write,
  input  wire logic [7:0] db_in,
  output logic      [7:0] db_out,
  output logic            db_oe,
  input  wire logic       chip_select_n,
  input  wire logic       serial_in,
  input  wire logic       serial_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            busy_indicator,
  output logic            cmd_ready
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    clh_mode_t                  mode;
    logic                       strap_taken;
    logic                       e_q;
    logic                       nib_lo;
    logic [3:0]                 nib_hi;
    logic [7:0]                 rd_val;
    logic [7:0]                 db_q;
    logic                       sclk_q;
    logic [2:0]                 spi_cnt;
    logic [6:0]                 spi_sh;
    logic                       scl_q;
    logic                       sda_q;
    clh_iphase_t                i_phase;
    logic [3:0]                 i_cnt;
    logic [7:0]                 i_sh;
    logic                       i_go;
    logic                       i_ack;
    logic                       i_co;
    logic                       i_a0;
    clh_entry_t [1:0]           fifo;
    logic [1:0]                 fifo_cnt;
    logic [15:0]                busy_cnt;
    logic [6:0]                 address_counter;
    logic                       sel_dd;
    logic                       inc;
    logic                       bus_width_bit;
    logic                       two_line;
    logic [7:0]                 dout;
    logic [DD_DEPTH-1:0][7:0]   display_text_ram;
    logic [CG_DEPTH-1:0][7:0]   glyph_pattern_ram;
  } clh_state_t;

  clh_state_t s;
  clh_state_t next_s;

  // Next address for a step, honouring the line layout of display RAM
  function automatic logic [6:0] step_ac(input logic [6:0] ac, input logic up,
                                         input logic dd, input logic two);
    logic [6:0] r;
    r = up ? ac + 7'h01 : ac - 7'h01;
    if (!dd)
      r[6] = 1'b0;
    else if (!two)
    begin
      if (up && ac == `CLH_DD_ONE_END)
        r = `CLH_DD_FIRST;
      else if (!up && ac == `CLH_DD_FIRST)
        r = `CLH_DD_ONE_END;
    end
    else
    begin
      if (up && ac == `CLH_DD_LINE1_END)
        r = `CLH_DD_LINE2_BEG;
      else if (up && ac == `CLH_DD_LINE2_END)
        r = `CLH_DD_FIRST;
      else if (!up && ac == `CLH_DD_LINE2_BEG)
        r = `CLH_DD_LINE1_END;
      else if (!up && ac == `CLH_DD_FIRST)
        r = `CLH_DD_LINE2_END;
    end
    return r;
  endfunction : step_ac

  // RAM byte at an address in the selected RAM
  function automatic logic [7:0] ram_rd(input clh_state_t st, input logic [6:0] ac,
                                        input logic dd);
    return dd ? st.display_text_ram[ac] : st.glyph_pattern_ram[ac[5:0]];
  endfunction : ram_rd

  logic       exec;
  clh_entry_t head;
  logic       e_fall;
  logic       e_rise;

  assign exec = (s.fifo_cnt != 2'd0) && (s.busy_cnt == 16'h0000);
  assign head = s.fifo[0];
  assign e_rise = (s.mode == CLH_PAR) && e_strobe && !s.e_q;
  assign e_fall = (s.mode == CLH_PAR) && !e_strobe && s.e_q;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic       push;
    clh_entry_t pv;
    logic [7:0] rv;
    logic [7:0] b;
    logic [1:0] cnt;
    logic       busy;
    next_s = s;
    push = 1'b0;
    pv = '0;
    cnt = s.fifo_cnt;
    b = {s.i_sh[6:0], sda_in};
    busy = (s.busy_cnt != 16'h0000) || (s.fifo_cnt != 2'd0);
    rv = reg_select ? s.dout : {busy, s.address_counter};
    next_s.e_q = e_strobe;
    next_s.sclk_q = serial_clk;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    if (!s.strap_taken)
    begin
      next_s.strap_taken = 1'b1;
      next_s.mode = iface_strap_low ? CLH_I2C : (iface_strap_high ? CLH_SPI : CLH_PAR);
    end

    // Parallel bus: reads answer from E rise, transfers complete at E fall
    if (e_rise && read_not_write)
    begin
      if (!s.nib_lo)
        next_s.rd_val = rv;
      if (s.bus_width_bit)
        next_s.db_q = rv;
      else
        next_s.db_q = s.nib_lo ? {s.rd_val[3:0], 4'h0} : {rv[7:4], 4'h0};
    end
    if (e_fall)
    begin
      if (!s.bus_width_bit)
        next_s.nib_lo = !s.nib_lo;
      if (!s.bus_width_bit && !s.nib_lo)
        next_s.nib_hi = db_in[7:4];
      else if (!read_not_write)
      begin
        push = 1'b1;
        pv.rs = reg_select;
        pv.data = s.bus_width_bit ? db_in : {s.nib_hi, db_in[7:4]};
      end
      else if (reg_select)
      begin
        next_s.address_counter = step_ac(s.address_counter, s.inc, s.sel_dd,
                                         s.two_line);
        next_s.dout = ram_rd(s, next_s.address_counter, s.sel_dd);
      end
    end

    // SPI: clock idles high, bits taken on rising edge, MSB first
    if (s.mode == CLH_SPI)
    begin
      if (chip_select_n)
        next_s.spi_cnt = 3'd0;
      else if (serial_clk && !s.sclk_q)
      begin
        next_s.spi_sh = {s.spi_sh[5:0], serial_in};
        next_s.spi_cnt = s.spi_cnt + 3'd1;
        if (s.spi_cnt == 3'd7)
        begin
          push = 1'b1;
          pv.rs = reg_select;
          pv.data = {s.spi_sh, serial_in};
        end
      end
    end

    // I2C slave, write only
    if (s.mode == CLH_I2C)
    begin
      if (s.scl_q && scl_in && s.sda_q && !sda_in)
      begin
        next_s.i_phase = CLH_I_ADDR;
        next_s.i_cnt = 4'h0;
        next_s.i_ack = 1'b0;
      end
      else if (s.scl_q && scl_in && !s.sda_q && sda_in)
      begin
        next_s.i_phase = CLH_I_IDLE;
        next_s.i_ack = 1'b0;
      end
      else if (scl_in && !s.scl_q && s.i_phase != CLH_I_IDLE
               && s.i_cnt < `CLH_I2C_BYTE_BITS)
      begin
        next_s.i_sh = b;
        next_s.i_cnt = s.i_cnt + 4'h1;
        if (s.i_cnt == `CLH_I2C_BYTE_BITS - 4'h1)
        begin
          next_s.i_go = 1'b0;
          unique case (s.i_phase)
            CLH_I_ADDR:
            begin
              if (b[7:1] == {`CLH_I2C_ADDR_HI, addr_strap_high, addr_strap_low}
                  && !b[0])
              begin
                next_s.i_go = 1'b1;
                next_s.i_phase = CLH_I_CTRL;
              end
              else
                next_s.i_phase = CLH_I_IDLE;
            end
            CLH_I_CTRL:
            begin
              next_s.i_co = b[7];
              next_s.i_a0 = b[6];
              next_s.i_go = 1'b1;
              next_s.i_phase = CLH_I_DATA;
            end
            CLH_I_DATA:
            begin
              if (s.fifo_cnt != 2'd2 || exec)
              begin
                push = 1'b1;
                pv.rs = s.i_a0;
                pv.data = b;
                next_s.i_go = 1'b1;
                next_s.i_phase = s.i_co ? CLH_I_CTRL : CLH_I_DATA;
              end
            end
            CLH_I_IDLE:
              next_s.i_go = 1'b0;
          endcase
        end
      end
      else if (!scl_in && s.scl_q)
      begin
        if (s.i_cnt == `CLH_I2C_BYTE_BITS)
        begin
          next_s.i_ack = s.i_go;
          next_s.i_cnt = s.i_cnt + 4'h1;
        end
        else if (s.i_cnt > `CLH_I2C_BYTE_BITS)
        begin
          next_s.i_ack = 1'b0;
          next_s.i_cnt = 4'h0;
          if (!s.i_go)
            next_s.i_phase = CLH_I_IDLE;
        end
      end
    end

    // Executor: one buffered word whenever the previous operation has ended
    if (s.busy_cnt != 16'h0000)
      next_s.busy_cnt = s.busy_cnt - 16'h0001;
    if (exec)
    begin
      next_s.busy_cnt = 16'(BUSY_CYC);
      if (head.rs)
      begin
        if (s.sel_dd)
          next_s.display_text_ram[s.address_counter] = head.data;
        else
          next_s.glyph_pattern_ram[s.address_counter[5:0]] = head.data;
        next_s.address_counter = step_ac(s.address_counter, s.inc, s.sel_dd,
                                         s.two_line);
      end
      else if (head.data[7])
      begin
        next_s.address_counter = head.data[6:0];
        next_s.sel_dd = 1'b1;
        next_s.dout = ram_rd(s, head.data[6:0], 1'b1);
      end
      else if (head.data[6])
      begin
        next_s.address_counter = {1'b0, head.data[5:0]};
        next_s.sel_dd = 1'b0;
      end
      else if (head.data[5])
      begin
        next_s.bus_width_bit = head.data[4];
        next_s.two_line = head.data[3];
      end
      else if (head.data[4] && !head.data[3])
      begin
        next_s.address_counter = step_ac(s.address_counter, head.data[2], s.sel_dd,
                                         s.two_line);
        next_s.dout = ram_rd(s, next_s.address_counter, s.sel_dd);
      end
      else if (head.data[2])
        next_s.inc = head.data[1];
    end

    // Two-entry buffer: pop the head, then append
    cnt = exec ? s.fifo_cnt - 2'd1 : s.fifo_cnt;
    if (exec)
      next_s.fifo[0] = s.fifo[1];
    if (push && cnt != 2'd2)
    begin
      next_s.fifo[cnt[0]] = pv;
      cnt = cnt + 2'd1;
    end
    next_s.fifo_cnt = cnt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.mode <= CLH_PAR;
      s.i_phase <= CLH_I_IDLE;
      s.address_counter <= `CLH_AC_RESET;
      s.sel_dd <= 1'b1;
      s.inc <= `CLH_INC_RESET;
      s.bus_width_bit <= `CLH_DL_RESET;
      s.two_line <= `CLH_LINES_RESET;
    end
    else
      s <= next_s;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign db_out = s.db_q;
  assign db_oe = (s.mode == CLH_PAR) && e_strobe && s.e_q && read_not_write;
  assign sda_out = 1'b0;
  assign sda_oe = s.i_ack;
  assign busy_indicator = (s.busy_cnt != 16'h0000) || (s.fifo_cnt != 2'd0);
  assign cmd_ready = (s.fifo_cnt != 2'd2);

  // ****************************************************************
  // Checks
  // ****************************************************************
  dd_set_a: assert property (@(posedge clk) disable iff (reset)
    exec && !head.rs && head.data[7] |=> s.sel_dd && s.address_counter == $past(head.data[6:0]))
    else $error("display address set not loaded");
  cg_set_a: assert property (@(posedge clk) disable iff (reset)
    exec && !head.rs && head.data[7:6] == 2'b01 |=> !s.sel_dd
      && s.address_counter == {1'b0, $past(head.data[5:0])})
    else $error("glyph address set not loaded");
  one_line_wrap_a: assert property (@(posedge clk) disable iff (reset)
    exec && head.rs && s.sel_dd && !s.two_line && s.inc && s.address_counter == `CLH_DD_ONE_END
    |=> s.address_counter == `CLH_DD_FIRST)
    else $error("one-line wrap wrong");
  two_line_wrap_a: assert property (@(posedge clk) disable iff (reset)
    exec && head.rs && s.sel_dd && s.two_line && s.inc && s.address_counter == `CLH_DD_LINE1_END
    |=> s.address_counter == `CLH_DD_LINE2_BEG)
    else $error("two-line wrap wrong");
  ram_write_a: assert property (@(posedge clk) disable iff (reset)
    exec && head.rs && s.sel_dd
    |=> s.display_text_ram[$past(s.address_counter)] == $past(head.data))
    else $error("display write lost");
  keep_prefetch_a: assert property (@(posedge clk) disable iff (reset)
    exec && head.rs |=> $stable(s.dout))
    else $error("write disturbed prefetch");
  nibble_busy_a: assert property (@(posedge clk) disable iff (reset)
    e_fall && !s.bus_width_bit && !s.nib_lo && !exec |=> s.fifo_cnt == $past(s.fifo_cnt))
    else $error("first nibble queued");
  busy_hold_a: assert property (@(posedge clk) disable iff (reset)
    exec |=> busy_indicator [*8])
    else $error("busy dropped early");
  ack_mode_a: assert property (@(posedge clk) disable iff (reset)
    sda_oe |-> s.mode == CLH_I2C)
    else $error("ack outside I2C mode");

endmodule : clh_host_if

// ### clh_host_model.sv
// Host side model for the character display host port: parallel, SPI and I2C masters.
// Assumes the testbench calls its tasks and the design samples every pin on clk.
`timescale 1ns/1ns

module clh_host_model
  import clh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] db_out,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  output logic            e_strobe,
  output logic            reg_select,
  output logic            read_not_write,
  output logic      [7:0] db_in,
  output logic            chip_select_n,
  output logic            serial_in,
  output logic            serial_clk,
  output logic            scl_in,
  output wire logic       sda_in
);
  logic host_sda;

  // Pulled-up line, low while either party pulls it
  assign sda_in = host_sda & ~(sda_oe & ~sda_out);

  initial
  begin
    e_strobe       = 1'b0;
    reg_select     = 1'b0;
    read_not_write = 1'b0;
    db_in          = 8'h00;
    chip_select_n  = 1'b1;
    serial_in      = 1'b0;
    serial_clk     = 1'b1;
    scl_in         = 1'b1;
    host_sda       = 1'b1;
  end

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
  endtask : edges

  // ****************************************
  // Parallel cycle, slow stretches the strobe
  // ****************************************
  task automatic par_cycle(input logic rs, input logic rnw, input logic [7:0] val,
                           output logic [7:0] rd, input int slow);
    @(posedge clk);
    reg_select     <= rs;
    read_not_write <= rnw;
    db_in          <= val;
    e_strobe       <= 1'b1;
    edges(3 + slow);
    rd = db_out;
    e_strobe <= 1'b0;
    // Data and select stand until the strobe fall has been sampled
    edges(1);
    db_in    <= ~val;
    edges(1);
  endtask : par_cycle

  // ****************************************
  // SPI frame, MSB first, clock idles high
  // ****************************************
  task automatic spi_frame(input logic rs, input logic [7:0] val, input int nbits);
    @(posedge clk);
    chip_select_n <= 1'b0;
    reg_select    <= rs;
    edges(2);
    for (int i = 0; i < nbits; i++)
    begin
      serial_clk <= 1'b0;
      serial_in  <= val[7 - i];
      edges(2);
      serial_clk <= 1'b1;
      edges(2);
    end
    chip_select_n <= 1'b1;
    serial_in     <= ~serial_in;
    edges(2);
  endtask : spi_frame

  // ****************************************
  // I2C master
  // ****************************************
  task automatic i2c_start();
    @(posedge clk);
    chip_select_n <= 1'b0;
    edges(2);
    host_sda <= 1'b0;
    edges(2);
    scl_in <= 1'b0;
    edges(2);
  endtask : i2c_start

  task automatic i2c_stop();
    host_sda <= 1'b0;
    edges(2);
    scl_in <= 1'b1;
    edges(2);
    host_sda <= 1'b1;
    edges(2);
  endtask : i2c_stop

  task automatic i2c_byte(input logic [7:0] val, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      host_sda <= val[i];
      edges(2);
      scl_in <= 1'b1;
      edges(2);
      scl_in <= 1'b0;
      edges(1);
    end
    host_sda <= 1'b1;
    edges(2);
    scl_in <= 1'b1;
    edges(2);
    ack = (sda_in === 1'b0);
    scl_in <= 1'b0;
    edges(2);
  endtask : i2c_byte
endmodule : clh_host_model

// ### clh_pkg.sv
// Types of the character display host port.
// Assumes clh_regs.svh supplies the numeric constants.
package clh_pkg;
  typedef enum logic [1:0] {CLH_PAR, CLH_I2C, CLH_SPI} clh_mode_t;
  typedef enum logic [1:0] {CLH_I_IDLE, CLH_I_ADDR, CLH_I_CTRL, CLH_I_DATA} clh_iphase_t;
  typedef struct packed
  {
    logic       rs;
    logic [7:0] data;
  } clh_entry_t;
endpackage : clh_pkg

// ### clh_regs.svh
// Constants of the character display host port: timing, address map, reset values.
// Assumes a single 250 MHz clock; included by bare name.
`ifndef CLH_REGS_SVH
`define CLH_REGS_SVH
`define CLH_CLK_NS        4
`define CLH_BUSY_NS       18500
`define CLH_I2C_ADDR_HI   5'h0F
`define CLH_DD_ONE_END    7'h4F
`define CLH_DD_LINE1_END  7'h27
`define CLH_DD_LINE2_BEG  7'h40
`define CLH_DD_LINE2_END  7'h67
`define CLH_DD_FIRST      7'h00
`define CLH_AC_RESET      7'h00
`define CLH_INC_RESET     1'b1
`define CLH_DL_RESET      1'b1
`define CLH_LINES_RESET   1'b0
`define CLH_I2C_BYTE_BITS 4'h8
`endif

// ### tb.sv
// Self-checking testbench of the character display host port.
// Assumes clh_host_model drives every host pin; straps are driven here.
`timescale 1ns/1ns

module tb;
  import clh_pkg::*;
  localparam int BUSY = 24;
  localparam int NR   = 31;
  typedef struct packed {logic rs; logic rnw; logic [7:0] val; logic [7:0] exp;} clh_row_t;

  logic       clk, reset, iface_strap_high, iface_strap_low, addr_strap_high, addr_strap_low;
  logic       e_strobe, reg_select, read_not_write, chip_select_n, serial_in, serial_clk;
  logic       scl_in, sda_in, sda_out, sda_oe, db_oe, busy_indicator, cmd_ready, ack;
  logic [7:0] db_in, db_out, rd, hi;
  int         miscompares, checks_done;
  logic [7:0] i2c_words [6] = '{8'h7A, 8'h80, 8'h83, 8'h40, 8'h5C, 8'h5D};

  // Rows: register select, read, value written, value expected on read
  clh_row_t rows [NR] = '{
    '{0, 0, 8'h85, 8'h00}, '{1, 0, 8'h11, 8'h00}, '{1, 0, 8'h22, 8'h00}, '{0, 1, 8'h00, 8'h07},
    '{0, 0, 8'h85, 8'h00}, '{1, 1, 8'h00, 8'h11}, '{1, 1, 8'h00, 8'h22}, '{0, 1, 8'h00, 8'h07},
    '{0, 0, 8'h90, 8'h00}, '{1, 0, 8'hAB, 8'h00}, '{1, 1, 8'h00, 8'h00}, '{0, 0, 8'h7F, 8'h00},
    '{1, 0, 8'h5A, 8'h00}, '{0, 1, 8'h00, 8'h00}, '{0, 0, 8'hCF, 8'h00}, '{1, 0, 8'h33, 8'h00},
    '{0, 1, 8'h00, 8'h00}, '{0, 0, 8'h38, 8'h00}, '{0, 0, 8'hA7, 8'h00}, '{1, 0, 8'h44, 8'h00},
    '{0, 1, 8'h00, 8'h40}, '{0, 0, 8'h04, 8'h00}, '{0, 0, 8'hC0, 8'h00}, '{1, 0, 8'h77, 8'h00},
    '{0, 1, 8'h00, 8'h27}, '{0, 0, 8'h06, 8'h00}, '{0, 0, 8'hA7, 8'h00}, '{1, 1, 8'h00, 8'h44},
    '{0, 0, 8'h10, 8'h00}, '{1, 1, 8'h00, 8'h44}, '{0, 1, 8'h00, 8'h40}};

  clh_host_if #(.BUSY_CYC(BUSY)) i_clh_host_if (
    .clk(clk), .reset(reset), .iface_strap_high(iface_strap_high),
    .iface_strap_low(iface_strap_low), .addr_strap_high(addr_strap_high),
    .addr_strap_low(addr_strap_low), .e_strobe(e_strobe), .reg_select(reg_select),
    .read_not_write(read_not_write), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_clk(serial_clk),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .busy_indicator(busy_indicator), .cmd_ready(cmd_ready));

  clh_host_model i_clh_host_model (
    .clk(clk), .db_out(db_out), .sda_out(sda_out), .sda_oe(sda_oe), .e_strobe(e_strobe),
    .reg_select(reg_select), .read_not_write(read_not_write), .db_in(db_in),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_clk(serial_clk),
    .scl_in(scl_in), .sda_in(sda_in));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic do_reset(input logic h, input logic l);
    @(posedge clk);
    iface_strap_high <= h;
    iface_strap_low  <= l;
    reset            <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (!(busy_indicator === 1'b0 && cmd_ready === 1'b1) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      miscompares++;
      $display("ERROR idle expected 1 seen 0");
      tally_and_finish();
    end
    repeat (2) @(posedge clk);
  endtask : wait_idle

  task automatic par(input logic rs, input logic rnw, input logic [7:0] val);
    i_clh_host_model.par_cycle(rs, rnw, val, rd, 0);
  endtask : par

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    reset = 1'b1;
    {iface_strap_high, iface_strap_low, addr_strap_high, addr_strap_low} = 4'h1;
    do_reset(1'b0, 1'b0);
    check("reset db_out", db_out, 8'h00);
    check("reset flags", {4'h0, sda_out, busy_indicator, cmd_ready, db_oe}, 8'h02);
    par(1'b1, 1'b1, 8'h00);
    check("first data read", rd, 8'h00);
    for (int i = 0; i < NR; i++)
    begin
      i_clh_host_model.par_cycle(rows[i].rs, rows[i].rnw, rows[i].val, rd, i % 2);
      if (rows[i].rnw)
        check("row", rd, rows[i].exp);
      wait_idle();
    end
    par(1'b0, 1'b0, 8'h80);
    par(1'b0, 1'b1, 8'h00);
    check("busy bit", {7'h00, rd[7]}, 8'h01);
    wait_idle();
    for (int i = 0; i < 4; i++)
    begin
      par(1'b1, 1'b0, 8'(8'hA1 + i));
      i_clh_host_model.edges(1);
      if (i == 2)
        check("ready when full", {7'h00, cmd_ready}, 8'h00);
    end
    wait_idle();
    par(1'b0, 1'b0, 8'h80);
    wait_idle();
    for (int i = 0; i < 4; i++)
    begin
      par(1'b1, 1'b1, 8'h00);
      check("buffered word", rd, (i < 3) ? 8'(8'hA1 + i) : 8'h00);
      wait_idle();
    end
    par(1'b0, 1'b0, 8'h28);
    wait_idle();
    par(1'b0, 1'b0, 8'h90);
    i_clh_host_model.edges(1);
    check("busy first nibble", {7'h00, busy_indicator}, 8'h00);
    par(1'b0, 1'b0, 8'h20);
    i_clh_host_model.edges(1);
    check("busy second nibble", {7'h00, busy_indicator}, 8'h01);
    wait_idle();
    par(1'b1, 1'b0, 8'hC0);
    par(1'b1, 1'b0, 8'h30);
    wait_idle();
    par(1'b0, 1'b0, 8'h90);
    par(1'b0, 1'b0, 8'h20);
    wait_idle();
    par(1'b1, 1'b1, 8'h00);
    hi = rd;
    par(1'b1, 1'b1, 8'h00);
    check("nibble data", {hi[7:4], rd[7:4]}, 8'hC3);
    check("unused lines", {4'h0, rd[3:0]}, 8'h00);
    wait_idle();
    par(1'b0, 1'b1, 8'h00);
    hi = rd;
    par(1'b0, 1'b1, 8'h00);
    check("nibble counter", {hi[7:4], rd[7:4]}, 8'h13);
    do_reset(1'b1, 1'b0);
    i_clh_host_model.spi_frame(1'b0, 8'h85, 7);
    par(1'b0, 1'b0, 8'h85);
    i_clh_host_model.edges(2);
    check("no word pushed", {7'h00, busy_indicator}, 8'h00);
    i_clh_host_model.spi_frame(1'b0, 8'h85, 8);
    check("spi word pushed", {7'h00, busy_indicator}, 8'h01);
    do_reset(1'b0, 1'b1);
    i_clh_host_model.i2c_start();
    i_clh_host_model.i2c_byte(8'h7A, ack);
    check("address ack", {7'h00, ack}, 8'h01);
    i_clh_host_model.i2c_byte(8'h00, ack);
    check("control ack", {7'h00, ack}, 8'h01);
    i_clh_host_model.i2c_byte(8'h38, ack);
    check("data ack and busy", {6'h00, ack, busy_indicator}, 8'h03);
    i_clh_host_model.i2c_stop();
    wait_idle();
    for (int i = 0; i < 2; i++)
    begin
      i_clh_host_model.i2c_start();
      i_clh_host_model.i2c_byte((i == 0) ? 8'h78 : 8'h7B, ack);
      check("refused address", {7'h00, ack}, 8'h00);
      i_clh_host_model.i2c_stop();
    end
    // Two command words: address set, then RAM data with no further control bytes
    i_clh_host_model.i2c_start();
    for (int i = 0; i < 6; i++)
    begin
      i_clh_host_model.i2c_byte(i2c_words[i], ack);
      check("command word ack", {7'h00, ack}, 8'h01);
    end
    i_clh_host_model.i2c_stop();
    wait_idle();
    check("i2c ram first", i_clh_host_if.s.display_text_ram[3], 8'h5C);
    check("i2c ram second", i_clh_host_if.s.display_text_ram[4], 8'h5D);
    tally_and_finish();
  end
endmodule : tb
